// ### bench/bmc_an_model.sv
/*
  Negotiation engine model: starts a restart after anDelay cycles.
  Assumes anRestart is a level held until anStarted.
*/
`timescale 1ns/1ns
module bmc_an_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Restart handshake
  input wire logic anRestart,
  input wire logic [3:0] anDelay,
  output logic anStarted,
  // Result
  output logic anSpeed100,
  output logic anFullDuplex
);
  logic [3:0] cnt;
  assign anSpeed100 = 1'b1;
  assign anFullDuplex = 1'b0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      anStarted <= 1'b0;
    end else begin
      anStarted <= anRestart && cnt == anDelay && !anStarted;
      cnt <= (anRestart && !anStarted) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ### bench/bmc_checker.sv
/*
  Port checker for the control register block.
  Bound to the block; sees only its ports.
*/
`timescale 1ns/1ns
module bmc_checker #(
  parameter int LOOPBACK_DEAD_CYCLES = 20,
  parameter int SOFT_RESET_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic [15:0] regWriteData,
  input wire logic regRead,
  input wire logic [15:0] regReadData,
  input wire logic regReadValid,
  // Negotiation
  input wire logic anStarted,
  input wire logic anSpeed100,
  input wire logic anFullDuplex,
  input wire logic anEnable,
  input wire logic anRestart,
  // Port
  input wire logic softResetActive,
  input wire logic powerDown,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic txEn,
  input wire logic rxDv,
  input wire logic col,
  input wire logic miiOutEn
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic hit;
  logic keepAn;
  // Writes that may legally drop a pending restart are left out
  assign hit = regWrite && regAddr == 5'h00 && !softResetActive;
  assign keepAn = anRestart && !anStarted && !softResetActive
    && !(hit && (!regWriteData[12] || regWriteData[15]));
  chk_read_answer: assert property (
    regRead && regAddr == 5'h00 |=> regReadValid) else $error("no answer");
  chk_reserved_zero: assert property (
    regReadValid |-> regReadData[6:0] == 7'h00) else $error("low bits");
  chk_restart_set: assert property (
    hit && regWriteData[12] && regWriteData[9] && !regWriteData[15]
    |=> anRestart) else $error("restart lost");
  chk_restart_hold: assert property (
    keepAn |=> anRestart) else $error("restart dropped");
  chk_restart_clear: assert property (
    anRestart && anStarted && !regWrite |=> !anRestart)
    else $error("restart stuck");
  chk_speed_follow: assert property (
    anEnable |-> speed100 == anSpeed100 && fullDuplex == anFullDuplex)
    else $error("forced mode used");
  chk_col_rise: assert property (
    $rose(col) |-> $past(txEn)) else $error("col without txEn");
  chk_col_fall: assert property (
    $fell(txEn) |-> ##[0:4] !col) else $error("col late");
  chk_port_quiet: assert property (
    powerDown || !miiOutEn |=> !rxDv && !col) else $error("port active");
  cover property (anRestart && anStarted);
  cover property (txEn && col);
  cover property ($fell(softResetActive));
endmodule
bind bmc_basic_mode_control bmc_checker #(
  .LOOPBACK_DEAD_CYCLES(LOOPBACK_DEAD_CYCLES),
  .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) bmc_checker_i (.*);

// ### bench/tb_top.sv
/*
  Testbench for the control register block.
  Assumes short counts: 20 dead cycles, 4 soft reset cycles.
*/
`timescale 1ns/1ns
module tb_top;
  logic clock, rst, strapAutoNeg, strapSpeed100, strapFullDuplex;
  logic regWrite, regRead, regReadValid, txEn, lineRxDv, lineCol;
  logic anStarted, anSpeed100, anFullDuplex, anEnable, anRestart;
  logic softResetActive, powerDown, speed100, fullDuplex;
  logic rxDv, col, miiOutEn;
  logic [4:0] regAddr;
  logic [15:0] regWriteData, regReadData;
  logic [3:0] txd, lineRxd, rxd, anDelay;
  int fails, num_checks, i;
  bmc_basic_mode_control #(.LOOPBACK_DEAD_CYCLES(20),
    .SOFT_RESET_CYCLES(4)) bmc_basic_mode_control_i (.*);
  bmc_an_model bmc_an_model_i (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [16:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [16:0] e);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    chk("read", e, {regReadValid, regReadData});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst, strapAutoNeg, strapSpeed100, strapFullDuplex} = 4'hF;
    {regWrite, regRead, txEn, lineCol, regAddr} = 9'h000;
    {regWriteData, txd, lineRxDv, lineRxd} = 25'h000A5 << 1 | 25'h10;
    anDelay = 4'hC;
    fails = 0;
    num_checks = 0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    rd(5'h00, 17'h13100);
    chk("mode", 17'h2, 17'({speed100, fullDuplex}));
    wr(5'h00, 16'h0100);
    chk("mode", 17'h1, 17'({speed100, fullDuplex}));
    wr(5'h00, 16'h2000);
    chk("mode", 17'h2, 17'({speed100, fullDuplex}));
    wr(5'h01, 16'h0800);
    rd(5'h01, 17'h00000);
    wr(5'h00, 16'h027F);
    rd(5'h00, 17'h10000);
    wr(5'h00, 16'h1200);
    chk("restart", 17'h1, 17'(anRestart));
    rd(5'h00, 17'h11200);
    wr(5'h00, 16'h1000);
    chk("restart", 17'h1, 17'(anRestart));
    for (i = 0; i < 30 && anRestart; i++) @(negedge clock);
    chk("restart", 17'h0, 17'(anRestart));
    rd(5'h00, 17'h11000);
    wr(5'h00, 16'h0080);
    txEn = 1'b1;
    repeat (2) @(negedge clock);
    chk("col", 17'h1, 17'(col));
    txEn = 1'b0;
    repeat (2) @(negedge clock);
    chk("col", 17'h0, 17'(col));
    wr(5'h00, 16'h4000);
    txEn = 1'b1;
    @(negedge clock);
    chk("dead", 17'h0, 17'(rxDv));
    repeat (25) @(negedge clock);
    chk("loop", 17'h1A, 17'({rxDv, rxd}));
    wr(5'h00, 16'h4400);
    @(negedge clock);
    chk("isolate", 17'h0, 17'({miiOutEn, rxDv}));
    rd(5'h00, 17'h14400);
    wr(5'h00, 16'h0800);
    chk("power", 17'h2, 17'({powerDown, rxDv}));
    rd(5'h00, 17'h10800);
    // New strap levels prove the soft reset samples them again
    {strapAutoNeg, strapSpeed100} = 2'b00;
    wr(5'h00, 16'h8000);
    chk("soft", 17'h1, 17'(softResetActive));
    rd(5'h00, 17'h18000);
    wr(5'h00, 16'h4000);
    for (i = 0; i < 30 && softResetActive; i++) @(negedge clock);
    chk("soft", 17'h0, 17'(softResetActive));
    @(negedge clock);
    rd(5'h00, 17'h10100);
    tally_and_finish;
  end
endmodule

// ### core/bmc_basic_mode_control.sv
/*
  Basic mode control register of a 10/100 transceiver, with the effect of
  each bit on the port: soft reset, loopback, forced speed and duplex,
  auto-negotiation enable and restart, power down, isolate, collision test.
  Assumes a management frame decoder delivers one-cycle read and write
  strobes with address and data, that an auto-negotiation engine reports
  when a restart has begun, and that strap pins are stable at reset.
*/
// Notes on behaviour
// - Writing one to bit 15 starts soft reset; reads one until done, restraps.
// - Bit 14 loops transmit data back onto the receive path.
// - Loopback entry may blank receive data for up to 500 us.
// - Auto-negotiation off: bit 13 one is 100 Mb/s, zero is 10 Mb/s.
// - Bit 12 enables negotiation, strapped at reset; then bits 8, 13 ignored.
// - Bit 11 powers down the port; registers stay accessible.
// - Bit 10 isolates the port from the MII; management still works.
// - Writing one to bit 9 restarts negotiation; self-clears; ignored if bit 12 zero.
// - Writing zero to bit 9 never disturbs a pending or running restart unless bit 12 is written zero or bit 15 one.
// - Auto-negotiation off: bit 8 one is full duplex, zero is half.
// - Collision test: COL rises within 512 bit times of TX_EN rising.
// - Collision test: COL falls within 4 bit times of TX_EN falling.
// - Bits 6 to 0 ignore writes and read zero.
// - Self-clearing bits accept writes, then clear once their action took hold.
`timescale 1ns/1ns

module bmc_basic_mode_control #(
  parameter int LOOPBACK_DEAD_CYCLES = bmc_pkg::BMC_LOOPBACK_DEAD_CYCLES,
  parameter int SOFT_RESET_CYCLES = bmc_pkg::BMC_SOFT_RESET_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Straps
  input wire logic strapAutoNeg,
  input wire logic strapSpeed100,
  input wire logic strapFullDuplex,
  // Management register port
  input wire logic [bmc_pkg::BMC_ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [bmc_pkg::BMC_DATA_W-1:0] regWriteData,
  input wire logic regRead,
  output logic [bmc_pkg::BMC_DATA_W-1:0] regReadData,
  output logic regReadValid,
  // Auto-negotiation engine
  input wire logic anStarted,
  input wire logic anSpeed100,
  input wire logic anFullDuplex,
  output logic anEnable,
  output logic anRestart,
  // Port control
  output logic softResetActive,
  output logic powerDown,
  output logic speed100,
  output logic fullDuplex,
  // MII transmit side from the MAC
  input wire logic txEn,
  input wire logic [3:0] txd,
  // Receive side from the line
  input wire logic lineRxDv,
  input wire logic [3:0] lineRxd,
  input wire logic lineCol,
  // MII receive side to the MAC
  output logic rxDv,
  output logic [3:0] rxd,
  output logic col,
  output logic miiOutEn
);
  import bmc_pkg::*;

  localparam int DEAD_W = $clog2(LOOPBACK_DEAD_CYCLES + 1);
  localparam int SRST_W = $clog2(SOFT_RESET_CYCLES + 1);

  logic loopback;
  logic speedSel;
  logic autoNeg;
  logic isolate;
  logic duplexSel;
  logic colTest;
  logic loadStraps;
  logic restartPending;
  logic [SRST_W-1:0] srstCount;
  logic [DEAD_W-1:0] deadCount;
  logic writeHit;
  logic [BMC_DATA_W-1:0] controlWord;

  // ****************************************
  // Register access
  // ****************************************
  // Writes during soft reset are dropped; the reset reloads everything
  assign writeHit = regWrite && regAddr == BMC_ADDR_CONTROL
    && !softResetActive;

  // Strap capture at hardware reset release and at soft reset end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loadStraps <= 1'b1;
    end else begin
      loadStraps <= softResetActive && srstCount == SRST_W'(1);
    end
  end

  // Soft reset sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      softResetActive <= 1'b0;
      srstCount <= '0;
    end else if (writeHit && regWriteData[BMC_BIT_RESET]) begin
      softResetActive <= 1'b1;
      srstCount <= SRST_W'(SOFT_RESET_CYCLES);
    end else if (softResetActive) begin
      srstCount <= srstCount - SRST_W'(1);
      if (srstCount == SRST_W'(1)) begin
        softResetActive <= 1'b0;
      end
    end
  end

  // ****************************************
  // Plain read-write bits
  // ****************************************
  // Loopback; a soft reset drops it like every other plain bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loopback <= BMC_RST_LOOPBACK;
    end else if (loadStraps) begin
      loopback <= BMC_RST_LOOPBACK;
    end else if (writeHit) begin
      loopback <= regWriteData[BMC_BIT_LOOPBACK];
    end
  end

  // Power down; the register block itself keeps running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerDown <= BMC_RST_POWERDOWN;
    end else if (loadStraps) begin
      powerDown <= BMC_RST_POWERDOWN;
    end else if (writeHit) begin
      powerDown <= regWriteData[BMC_BIT_POWERDOWN];
    end
  end

  // Isolate; management access is untouched by it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      isolate <= BMC_RST_ISOLATE;
    end else if (loadStraps) begin
      isolate <= BMC_RST_ISOLATE;
    end else if (writeHit) begin
      isolate <= regWriteData[BMC_BIT_ISOLATE];
    end
  end

  // Collision test
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      colTest <= BMC_RST_COLTEST;
    end else if (loadStraps) begin
      colTest <= BMC_RST_COLTEST;
    end else if (writeHit) begin
      colTest <= regWriteData[BMC_BIT_COLTEST];
    end
  end

  // Forced speed, forced duplex and negotiation enable reload from straps.
  // After hardware reset they read zero for one edge; in soft reset they keep bits 13, 12 and 8 of the write that began it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      speedSel <= 1'b0;
      duplexSel <= 1'b0;
      autoNeg <= 1'b0;
    end else if (loadStraps) begin
      speedSel <= strapSpeed100;
      duplexSel <= strapFullDuplex;
      autoNeg <= strapAutoNeg;
    end else if (writeHit) begin
      speedSel <= regWriteData[BMC_BIT_SPEED];
      autoNeg <= regWriteData[BMC_BIT_AUTONEG];
      duplexSel <= regWriteData[BMC_BIT_DUPLEX];
    end
  end

  // Restart request: a written one sets it, the engine's start clears it.
  // A write of zero is no clear at all, and a new set beats the clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      restartPending <= 1'b0;
    end else if (loadStraps) begin
      restartPending <= 1'b0;
    end else if (writeHit && regWriteData[BMC_BIT_RESTART]
        && regWriteData[BMC_BIT_AUTONEG]) begin
      restartPending <= 1'b1;
    end else if (anStarted || !autoNeg) begin
      restartPending <= 1'b0;
    end
  end

  assign controlWord = {
    softResetActive,
    loopback,
    speedSel,
    autoNeg,
    powerDown,
    isolate,
    restartPending,
    duplexSel,
    colTest,
    BMC_RESERVED_READ
  };

  // Read answer flag, one cycle after the read strobe.
  // A read of another address gives no valid; another block answers it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead && regAddr == BMC_ADDR_CONTROL;
    end
  end

  // Read data held in flops; zero between answers keeps a shared bus clean
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regReadData <= '0;
    end else if (regRead && regAddr == BMC_ADDR_CONTROL) begin
      regReadData <= controlWord;
    end else begin
      regReadData <= '0;
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  assign anEnable = autoNeg;
  assign anRestart = restartPending;
  assign speed100 = autoNeg ? anSpeed100 : speedSel;
  assign fullDuplex = autoNeg ? anFullDuplex : duplexSel;

  // ****************************************
  // Loopback dead time
  // ****************************************
  // Receive stays blank after loopback entry while the descrambler relocks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      deadCount <= '0;
    end else if (writeHit && regWriteData[BMC_BIT_LOOPBACK] && !loopback) begin
      deadCount <= DEAD_W'(LOOPBACK_DEAD_CYCLES);
    end else if (!loopback) begin
      deadCount <= '0;
    end else if (deadCount != '0) begin
      deadCount <= deadCount - DEAD_W'(1);
    end
  end

  // ****************************************
  // MII receive path and collision
  // ****************************************
  // One cycle of latency meets both collision bounds at either speed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxDv <= 1'b0;
      rxd <= 4'h0;
    end else if (isolate || powerDown || softResetActive) begin
      rxDv <= 1'b0;
      rxd <= 4'h0;
    end else if (loopback) begin
      rxDv <= txEn && deadCount == '0;
      rxd <= deadCount == '0 ? txd : 4'h0;
    end else begin
      rxDv <= lineRxDv;
      rxd <= lineRxd;
    end
  end

  // Collision output, forced quiet while the port is shut off
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      col <= 1'b0;
    end else if (isolate || powerDown || softResetActive) begin
      col <= 1'b0;
    end else if (colTest) begin
      col <= txEn;
    end else begin
      col <= lineCol && !loopback;
    end
  end

  // Pins float toward the MAC while isolated
  assign miiOutEn = !isolate;

endmodule

// ### core/bmc_pkg.sv
/*
  Constants for the basic mode control register block: register offset,
  field positions, reset values and timing counts.
  Assumes a 100 MHz device clock.
*/
package bmc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] BMC_ADDR_CONTROL = 5'h00;
  localparam int BMC_DATA_W = 16;
  localparam int BMC_ADDR_W = 5;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BMC_BIT_RESET = 15;
  localparam int BMC_BIT_LOOPBACK = 14;
  localparam int BMC_BIT_SPEED = 13;
  localparam int BMC_BIT_AUTONEG = 12;
  localparam int BMC_BIT_POWERDOWN = 11;
  localparam int BMC_BIT_ISOLATE = 10;
  localparam int BMC_BIT_RESTART = 9;
  localparam int BMC_BIT_DUPLEX = 8;
  localparam int BMC_BIT_COLTEST = 7;

  // ****************************************
  // Reset values of the plain control bits
  // ****************************************
  localparam logic BMC_RST_LOOPBACK = 1'b0;
  localparam logic BMC_RST_POWERDOWN = 1'b0;
  localparam logic BMC_RST_ISOLATE = 1'b0;
  localparam logic BMC_RST_COLTEST = 1'b0;
  localparam logic [6:0] BMC_RESERVED_READ = 7'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int BMC_CLOCK_MHZ = 100;
  localparam int BMC_LOOPBACK_DEAD_US = 500;
  localparam int BMC_LOOPBACK_DEAD_CYCLES =
    BMC_LOOPBACK_DEAD_US * BMC_CLOCK_MHZ;
  localparam int BMC_SOFT_RESET_CYCLES = 16;
  localparam int BMC_COL_ASSERT_MAX_BIT_TIMES = 512;
  localparam int BMC_COL_DEASSERT_MAX_BIT_TIMES = 4;

endpackage
